// *** epc_params.svh ***
// Register indices, reset values and encodings for the pin interrupt block
`ifndef EPC_PARAMS_SVH
`define EPC_PARAMS_SVH
`define EPC_IDX_GROUP_ENABLE 8'h68
`define EPC_IDX_MASK_LOW 8'h6b
`define EPC_IDX_MASK_SECOND 8'h6c
`define EPC_IDX_MASK_THIRD 8'h6d
`define EPC_IDX_MASK_HIGH 8'h73
`define EPC_IDX_LINE_ENABLE 8'h60
`define EPC_IDX_LINE_FLAGS 8'h61
`define EPC_IDX_GROUP_FLAGS 8'h62
`define EPC_IDX_EVENT_STATUS 8'h63
`define EPC_IDX_EVENT_MASK 8'h64
`define EPC_RST_BYTE 8'h00
`define EPC_GROUP_EN_RW 8'h0f
`define EPC_SENSE_LOW 2'h0
`define EPC_SENSE_ANY 2'h1
`define EPC_SENSE_FALL 2'h2
`define EPC_SENSE_RISE 2'h3
`define EPC_RESP_OKAY 2'h0
`define EPC_RESP_SLVERR 2'h2
`define EPC_ACK_GROUP_BASE 3'h3
`define EPC_FILL_DONE 2'h3
`endif

// *** epc_pkg.sv ***
// Types shared by the pin interrupt block
package epc_pkg;
  typedef struct packed {
    logic [2:0] line;
    logic [31:0] watch;
  } epc_pins_t;

  typedef struct packed {
    logic aw_held;
    logic [7:0] aw_idx;
    logic w_held;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
  } epc_bus_t;

  typedef struct packed {
    epc_pins_t sync1;
    epc_pins_t sync2;
    epc_pins_t prev;
    logic [1:0] fill;
    logic [2:0] line_en;
    logic [2:0] line_flag;
    logic [3:0] grp_en;
    logic [3:0] grp_flag;
    logic [31:0] pmask;
    logic [6:0] ev_stat;
    logic [6:0] ev_mask;
    epc_bus_t bus;
  } epc_state_t;

  typedef struct packed {
    logic [3:0] group;
    logic [2:0] line;
  } epc_req_t;
endpackage : epc_pkg

// *** epc_irq.sv ***
// External line and pin change interrupt block with AXI4-Lite registers
// How it works
// (RULE1) Line requests need line enable and global enable
// (RULE2) Pins driven as outputs still raise requests
// (RULE3) Selected edge on a line sets its flag
// (RULE4) Set enabled line flag vectors; service clears it
// (RULE5) Write one clears line flag, zero keeps
// (RULE6) Level-sensed line flag always reads cleared
// (RULE7) Sleep-gated inputs may set line flags
// (RULE8) Four groups of eight pins, gated by enables
// (RULE9) Each group requests through its own vector
// (RULE10) Enabled pin change sets its group flag
// (RULE11) Group flag vectors; service or write-one clears
// (RULE12) Mask bit enables change detect per pin
// (RULE13) Group enable upper bits read zero; reset zero
// (RULE14) Sense codes: low, any, falling, rising edge
// (RULE15) Level mode requests while pin stays low
// (RULE16) Detection needs no separate I/O clock
// (RULE17) Acknowledge id clears flag; write clears immediately
// (RULE18) Pins synchronised before any edge compare
`timescale 1ns/1ps
`include "epc_params.svh"

module epc_irq #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Pins and core status
  input wire logic [2:0] dedicated_irq_lines_i,
  input wire logic [31:0] change_watch_pins_i,
  input wire logic [5:0] ext_sense_config_i,
  input wire logic core_status_word_gie_i,
  input wire logic sleep_i,
  // Core vectoring
  output epc_pkg::epc_req_t vector_req_o,
  input wire logic core_ack_i,
  input wire logic [2:0] core_ack_id_i,
  // Interrupt
  output logic irq_o,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  epc_pkg::epc_state_t q;
  epc_pkg::epc_state_t d;
  epc_pkg::epc_pins_t cur;
  logic armed;
  logic [2:0] lvl;
  logic [2:0] rise;
  logic [2:0] fall;
  logic [2:0] line_set;
  logic [3:0] grp_set;
  logic [31:0] chg;
  logic [2:0] ack_line;
  logic [3:0] ack_grp;
  logic wr_fire;
  logic [7:0] wr_bits;
  logic [7:0] rd_idx;
  logic [2:0] line_clr;
  logic [3:0] grp_clr;

  // Disabled lines lose their input buffer in sleep; the forced low may set a flag
  assign cur.line = q.sync2.line & ~({3{sleep_i}} & ~q.line_en); // [RULE7] [RULE2]
  assign cur.watch = q.sync2.watch; // [RULE2]
  // No compare until the synchronisers hold real pin values
  assign armed = (q.fill == `EPC_FILL_DONE);
  assign rise = cur.line & ~q.prev.line; // [RULE18]
  assign fall = ~cur.line & q.prev.line; // [RULE18]

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lvl[i] = (ext_sense_config_i[2*i +: 2] == `EPC_SENSE_LOW);
      case (ext_sense_config_i[2*i +: 2])
        `EPC_SENSE_ANY: line_set[i] = armed & (rise[i] | fall[i]); // [RULE14] [RULE3]
        `EPC_SENSE_FALL: line_set[i] = armed & fall[i]; // [RULE14]
        `EPC_SENSE_RISE: line_set[i] = armed & rise[i]; // [RULE14]
        default: line_set[i] = 1'b0;
      endcase
    end
  end

  // Plain sampled logic on the system clock; no second clock involved
  assign chg = (cur.watch ^ q.prev.watch) & q.pmask; // [RULE12] [RULE16]
  always_comb begin
    for (int g = 0; g < 4; g++) begin
      grp_set[g] = armed & q.grp_en[g] & (|chg[8*g +: 8]); // [RULE8] [RULE10]
      ack_grp[g] = core_ack_i && (core_ack_id_i == (`EPC_ACK_GROUP_BASE + 3'(g))); // [RULE17]
    end
    for (int i = 0; i < 3; i++) begin
      ack_line[i] = core_ack_i && (core_ack_id_i == 3'(i)); // [RULE17]
    end
  end

  assign wr_fire = q.bus.aw_held & q.bus.w_held & ~q.bus.bvalid;
  assign wr_bits = q.bus.w_strb0 ? q.bus.w_data : `EPC_RST_BYTE;
  assign rd_idx = s_axi_araddr[9:2];
  assign line_clr = ack_line |
    ((wr_fire && q.bus.aw_idx == `EPC_IDX_LINE_FLAGS) ? wr_bits[2:0] : 3'h0); // [RULE5] [RULE4]
  assign grp_clr = ack_grp |
    ((wr_fire && q.bus.aw_idx == `EPC_IDX_GROUP_FLAGS) ? wr_bits[3:0] : 4'h0); // [RULE11]

  always_comb begin
    d = q;
    d.sync1.line = dedicated_irq_lines_i; // [RULE18]
    d.sync1.watch = change_watch_pins_i;
    d.sync2 = q.sync1;
    d.prev = cur;
    if (!armed) begin
      d.fill = q.fill + 2'h1;
    end
    // Set beats clear when both land in one cycle
    d.line_flag = ((q.line_flag & ~line_clr) | line_set) & ~lvl; // [RULE3] [RULE5] [RULE6]
    d.grp_flag = (q.grp_flag & ~grp_clr) | grp_set; // [RULE10] [RULE11]
    d.ev_stat = q.ev_stat | {grp_set, line_set};

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.bus.aw_held = 1'b1;
      d.bus.aw_idx = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.bus.w_held = 1'b1;
      d.bus.w_data = s_axi_wdata[7:0];
      d.bus.w_strb0 = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      d.bus.aw_held = 1'b0;
      d.bus.w_held = 1'b0;
      d.bus.bvalid = 1'b1;
      d.bus.bresp = `EPC_RESP_OKAY;
      case (q.bus.aw_idx)
        `EPC_IDX_GROUP_ENABLE: d.grp_en = wr_bits[3:0]; // [RULE13]
        `EPC_IDX_MASK_LOW: d.pmask[7:0] = wr_bits; // [RULE12]
        `EPC_IDX_MASK_SECOND: d.pmask[15:8] = wr_bits;
        `EPC_IDX_MASK_THIRD: d.pmask[23:16] = wr_bits;
        `EPC_IDX_MASK_HIGH: d.pmask[31:24] = wr_bits;
        `EPC_IDX_LINE_ENABLE: d.line_en = wr_bits[2:0]; // [RULE1]
        `EPC_IDX_LINE_FLAGS: d.bus.bresp = `EPC_RESP_OKAY;
        `EPC_IDX_GROUP_FLAGS: d.bus.bresp = `EPC_RESP_OKAY;
        `EPC_IDX_EVENT_STATUS: d.ev_stat = (q.ev_stat & ~wr_bits[6:0]) | {grp_set, line_set};
        `EPC_IDX_EVENT_MASK: d.ev_mask = wr_bits[6:0];
        default: d.bus.bresp = `EPC_RESP_SLVERR;
      endcase
    end else if (q.bus.bvalid && s_axi_bready) begin
      d.bus.bvalid = 1'b0;
    end

    // Read channel: one word at a time, answer the cycle after the address
    if (s_axi_arvalid && s_axi_arready) begin
      d.bus.rvalid = 1'b1;
      d.bus.rresp = `EPC_RESP_OKAY;
      case (rd_idx)
        `EPC_IDX_GROUP_ENABLE: d.bus.rdata = {4'h0, q.grp_en} & `EPC_GROUP_EN_RW; // [RULE13]
        `EPC_IDX_MASK_LOW: d.bus.rdata = q.pmask[7:0];
        `EPC_IDX_MASK_SECOND: d.bus.rdata = q.pmask[15:8];
        `EPC_IDX_MASK_THIRD: d.bus.rdata = q.pmask[23:16];
        `EPC_IDX_MASK_HIGH: d.bus.rdata = q.pmask[31:24];
        `EPC_IDX_LINE_ENABLE: d.bus.rdata = {5'h00, q.line_en};
        `EPC_IDX_LINE_FLAGS: d.bus.rdata = {5'h00, q.line_flag & ~lvl}; // [RULE6]
        `EPC_IDX_GROUP_FLAGS: d.bus.rdata = {4'h0, q.grp_flag};
        `EPC_IDX_EVENT_STATUS: d.bus.rdata = {1'b0, q.ev_stat};
        `EPC_IDX_EVENT_MASK: d.bus.rdata = {1'b0, q.ev_mask};
        default: begin
          d.bus.rdata = `EPC_RST_BYTE;
          d.bus.rresp = `EPC_RESP_SLVERR;
        end
      endcase
    end else if (q.bus.rvalid && s_axi_rready) begin
      d.bus.rvalid = 1'b0;
    end
  end

  // Constant reset only; pins are caught after release through the synchroniser
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0; // [RULE13]
    end else begin
      q <= d;
    end
  end

  // Level mode follows the pin, edge modes follow the flag
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      vector_req_o.line[i] = core_status_word_gie_i & q.line_en[i] &
        (lvl[i] ? ~cur.line[i] : q.line_flag[i]); // [RULE1] [RULE4] [RULE15]
    end
    vector_req_o.group = q.grp_flag & q.grp_en & {4{core_status_word_gie_i}}; // [RULE9] [RULE11]
  end

  assign irq_o = |(q.ev_stat & q.ev_mask);
  assign s_axi_awready = ~q.bus.aw_held & ~q.bus.bvalid;
  assign s_axi_wready = ~q.bus.w_held & ~q.bus.bvalid;
  assign s_axi_bvalid = q.bus.bvalid;
  assign s_axi_bresp = q.bus.bresp;
  assign s_axi_arready = ~q.bus.rvalid;
  assign s_axi_rvalid = q.bus.rvalid;
  assign s_axi_rresp = q.bus.rresp;
  assign s_axi_rdata = {24'h000000, q.bus.rdata};

  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_rise_seen;
    armed && ext_sense_config_i[1:0] == `EPC_SENSE_RISE && rise[0];
  endsequence

  sequence s_level_held;
    lvl[0] ##1 lvl[0];
  endsequence

  a_line_req_gate: assert property (
    vector_req_o.line[0] |-> core_status_word_gie_i && q.line_en[0]) // [RULE1]
    else $error("line request without enables");

  a_rise_sets_flag: assert property (
    s_rise_seen ##0 (ext_sense_config_i[1:0] == `EPC_SENSE_RISE) |=> q.line_flag[0]) // [RULE3]
    else $error("rising edge did not set line flag");

  a_level_flag_zero: assert property (s_level_held |-> !q.line_flag[0]) // [RULE6]
    else $error("level line flag not cleared");

  a_level_request: assert property (
    lvl[1] && q.line_en[1] && core_status_word_gie_i && !cur.line[1]
    |-> vector_req_o.line[1]) // [RULE15]
    else $error("low level did not request");

  a_w1c_line: assert property (
    wr_fire && q.bus.aw_idx == `EPC_IDX_LINE_FLAGS && wr_bits[2] && !line_set[2]
    |=> !q.line_flag[2]) // [RULE5]
    else $error("write one did not clear line flag");

  a_w0_keeps: assert property (
    q.line_flag[2] && !lvl[2] && !ack_line[2] &&
    !(wr_fire && q.bus.aw_idx == `EPC_IDX_LINE_FLAGS && wr_bits[2])
    |=> q.line_flag[2]) // [RULE5]
    else $error("line flag lost without clear");

  a_ack_clears: assert property (
    core_ack_i && core_ack_id_i == 3'h4 && !grp_set[1] |=> !q.grp_flag[1]) // [RULE17]
    else $error("acknowledge did not clear group flag");

  a_set_wins: assert property (
    grp_set[0] && ack_grp[0] |=> q.grp_flag[0]) // [RULE11]
    else $error("clear beat a set event");

  a_group_vector: assert property (
    vector_req_o.group[2] |-> q.grp_flag[2] && q.grp_en[2] && core_status_word_gie_i) // [RULE9]
    else $error("group request without cause");

  a_masked_pin: assert property (
    $rose(q.grp_flag[3]) |-> $past(q.grp_en[3]) && $past(|chg[31:24])) // [RULE12]
    else $error("group flag rose without masked change");

  a_group_enable_rd: assert property (
    s_axi_arvalid && s_axi_arready && rd_idx == `EPC_IDX_GROUP_ENABLE
    |=> s_axi_rvalid && s_axi_rdata[7:4] == 4'h0) // [RULE13]
    else $error("group enable upper bits not zero");

  a_sync_depth: assert property (
    armed && $past(armed, 3) && !sleep_i && !$past(sleep_i) &&
    $rose(q.line_flag[0]) && $past(ext_sense_config_i[1:0]) == `EPC_SENSE_ANY
    |-> $past(dedicated_irq_lines_i[0], 3) != $past(dedicated_irq_lines_i[0], 4)) // [RULE18]
    else $error("line flag not tied to synchronised pin change");

  a_irq_level: assert property (irq_o |-> |(q.ev_stat & q.ev_mask))
    else $error("interrupt without unmasked status");

endmodule : epc_irq

// *** epc_pin_src.sv ***
// Model of the outside sources that drive the interrupt pins
`timescale 1ns/1ps

module epc_pin_src (
  // Clock
  input wire logic clock_i,
  // Pins
  output epc_pkg::epc_pins_t pins_o
);
  // Lines idle high so low level sensing stays quiet
  initial pins_o = {3'h7, 32'h0};

  // A pin driven by the chip itself looks the same here
  task automatic put_line(input int i, input logic v);
    @(posedge clock_i);
    pins_o.line[i] <= v;
  endtask : put_line

  task automatic flip_watch(input int n);
    @(posedge clock_i);
    pins_o.watch[n] <= ~pins_o.watch[n];
  endtask : flip_watch
endmodule : epc_pin_src

// *** test_epc_irq.sv ***
// Self-checking bench for the pin interrupt block
`timescale 1ns/1ps
`include "epc_params.svh"

module test_epc_irq;
  localparam logic [7:0] GE = `EPC_IDX_GROUP_ENABLE;
  localparam logic [7:0] LE = `EPC_IDX_LINE_ENABLE;
  localparam logic [7:0] LF = `EPC_IDX_LINE_FLAGS;
  localparam logic [7:0] GF = `EPC_IDX_GROUP_FLAGS;
  localparam logic [7:0] ES = `EPC_IDX_EVENT_STATUS;
  localparam logic [7:0] EM = `EPC_IDX_EVENT_MASK;
  localparam logic [7:0] MA [4] = '{`EPC_IDX_MASK_LOW, `EPC_IDX_MASK_SECOND,
                                    `EPC_IDX_MASK_THIRD, `EPC_IDX_MASK_HIGH};
  logic clk = 0;
  logic rst_n = 0;
  logic gie = 1;
  logic sleep = 0;
  logic ack = 0;
  logic [2:0] ack_id = '0;
  logic [5:0] sense = 6'h3f;
  logic [11:0] awaddr = '0;
  logic [11:0] araddr = '0;
  logic awvalid = 0;
  logic wvalid = 0;
  logic arvalid = 0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awready, wready, bvalid, arready, rvalid, irq;
  epc_pkg::epc_req_t vreq;
  epc_pkg::epc_pins_t pins;
  int err_count = 0;
  int n_checks = 0;

  epc_pin_src src (.clock_i(clk), .pins_o(pins));
  // Response readies stay high: no back-pressure on answers
  epc_irq dut (.clock_i(clk), .rst_n_i(rst_n), .dedicated_irq_lines_i(pins.line),
    .change_watch_pins_i(pins.watch), .ext_sense_config_i(sense),
    .core_status_word_gie_i(gie), .sleep_i(sleep), .vector_req_o(vreq), .core_ack_i(ack),
    .core_ack_id_i(ack_id), .irq_o(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic give_verdict;
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask : chk

  // Readies are looked at settled, before the edge that takes the item
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
    logic aw_go;
    logic w_go;
    logic b_seen;
    logic [1:0] bv;
    b_seen = 1'b0;
    bv = 2'h0;
    awaddr <= {2'h0, i, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int t = 0; t < 60 && !b_seen; t++) begin
      #1;
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      b_seen = bvalid;
      bv = bresp;
      @(posedge clk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
    end
    chk("bvalid", 32'h1, {31'h0, b_seen});
    chk("bresp", {30'h0, er}, {30'h0, bv});
  endtask : wr

  task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic [1:0] er = 2'h0);
    logic ar_go;
    logic r_seen;
    logic [31:0] rv;
    logic [1:0] rr;
    r_seen = 1'b0;
    rv = '0;
    rr = 2'h0;
    araddr <= {2'h0, i, 2'h0};
    arvalid <= 1'b1;
    for (int t = 0; t < 60 && !r_seen; t++) begin
      #1;
      ar_go = arvalid && arready;
      r_seen = rvalid;
      rv = rdata;
      rr = rresp;
      @(posedge clk);
      if (ar_go) arvalid <= 1'b0;
    end
    chk("rvalid", 32'h1, {31'h0, r_seen});
    chk("rdata", {24'h0, e}, rv);
    chk("rresp", {30'h0, er}, {30'h0, rr});
  endtask : rd

  // Pin to flag takes three edges; one spare
  task automatic w4;
    repeat (4) @(posedge clk);
    #1;
  endtask : w4

  task automatic pin(input int i, input logic v, input logic [7:0] e);
    src.put_line(i, v);
    w4();
    rd(LF, e);
  endtask : pin

  task automatic svc(input logic [2:0] id);
    @(posedge clk);
    ack <= 1'b1;
    ack_id <= id;
    @(posedge clk);
    ack <= 1'b0;
  endtask : svc

  task automatic t_regs;
    rd(GE, 8'h00);
    for (int m = 0; m < 4; m++) rd(MA[m], 8'h00);
    wr(GE, 8'hff);
    rd(GE, 8'h0f);
    wr(8'hff, 8'h01, 2'h2);
    rd(8'hff, 8'h00, 2'h2);
  endtask : t_regs

  task automatic t_lines;
    wr(LE, 8'h07);
    pin(0, 1'b0, 8'h00);
    pin(0, 1'b1, 8'h01);
    chk("vec_line", 32'h1, {29'h0, vreq.line});
    svc(3'h0);
    rd(LF, 8'h00);
    sense[1:0] <= `EPC_SENSE_FALL;
    pin(0, 1'b0, 8'h01);
    wr(LF, 8'h00);
    rd(LF, 8'h01);
    wr(LF, 8'h01);
    rd(LF, 8'h00);
    pin(0, 1'b1, 8'h00);
    sense[1:0] <= `EPC_SENSE_ANY;
    pin(0, 1'b0, 8'h01);
    gie <= 1'b0;
    w4();
    chk("vec_line", 32'h0, {29'h0, vreq.line});
    gie <= 1'b1;
    wr(LF, 8'h01);
    pin(0, 1'b1, 8'h01);
    wr(LF, 8'h01);
  endtask : t_lines

  task automatic t_level;
    sense[5:4] <= `EPC_SENSE_LOW;
    pin(2, 1'b0, 8'h00);
    chk("vec_line", 32'h4, {29'h0, vreq.line});
    pin(2, 1'b1, 8'h00);
    chk("vec_line", 32'h0, {29'h0, vreq.line});
    sense[5:4] <= `EPC_SENSE_RISE;
  endtask : t_level

  task automatic t_groups;
    for (int g = 0; g < 4; g++) begin
      wr(GE, 8'h01 << g);
      wr(MA[g], 8'h01 << g);
      src.flip_watch(8 * g + (g + 1) % 8);
      w4();
      rd(GF, 8'h00);
      src.flip_watch(9 * g);
      w4();
      rd(GF, 8'h01 << g);
      chk("vec_group", 32'h1 << g, {28'h0, vreq.group});
      svc(3'h3 + 3'(g));
      rd(GF, 8'h00);
    end
    src.flip_watch(0);
    w4();
    rd(GF, 8'h00);
  endtask : t_groups

  task automatic t_irq;
    wr(ES, 8'h7f);
    wr(EM, 8'h7f);
    rd(ES, 8'h00);
    chk("irq", 32'h0, {31'h0, irq});
    pin(0, 1'b0, 8'h01);
    rd(ES, 8'h01);
    chk("irq", 32'h1, {31'h0, irq});
    wr(EM, 8'h00);
    w4();
    chk("irq", 32'h0, {31'h0, irq});
    wr(EM, 8'h7f);
    w4();
    chk("irq", 32'h1, {31'h0, irq});
    wr(ES, 8'h01);
    w4();
    chk("irq", 32'h0, {31'h0, irq});
    wr(LF, 8'h01);
  endtask : t_irq

  // Disabled line with inputs gated off in sleep reads low: any-edge sees it
  task automatic t_sleep;
    sense[3:2] <= `EPC_SENSE_ANY;
    wr(LE, 8'h05);
    sleep <= 1'b1;
    w4();
    rd(LF, 8'h02);
    sleep <= 1'b0;
  endtask : t_sleep

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_lines();
    t_level();
    t_groups();
    t_irq();
    t_sleep();
    give_verdict();
  end

  // Whole run needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end
endmodule : test_epc_irq
